// [hdl/timer_regs.svh]
// Register map, field positions and fixed counts of the 8-bit timer
// Overview of operation
// - Clock-source bit 5 clear, no prescaler: count once per instruction cycle.
// - Any write to the count holds off counting for two instruction cycles.
// - Clock-source bit set: count selected edges on the external count pin.
// - Edge bit 4: clear counts rising edges, set counts falling edges.
// - Rollover from FFh to 00h sets overflow flag, interrupt control bit 2.
// - Interrupt request only while overflow enable, bit 5, is set.
// - Counter stops during sleep, so it never wakes the processor.
// - External input sampled on phases Q2 and Q4; raw pin without prescaler.
// - One 8-bit prescaler; owner bit 3 clear gives timer, set gives watchdog.
// - Rate field: timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// - Prescaler value has no software read or write path.
// - Prescaler owned by timer: every count write clears the prescaler.
// - Prescaler owned by watchdog: watchdog clear resets prescaler and watchdog.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define TC_IDX_COUNT 8'h01
`define TC_IDX_INTCTL 8'h0B
`define TC_IDX_OPTION 8'h81

`define TC_OPT_RESET 8'hFF
`define TC_COUNT_RESET 8'h00
`define TC_COUNT_MAX 8'hFF

`define TC_OPT_SRC_BIT 5
`define TC_OPT_EDGE_BIT 4
`define TC_OPT_OWNER_BIT 3
`define TC_OPT_RATE_MSB 2
`define TC_OPT_RATE_LSB 0

`define TC_INT_FLAG_BIT 2
`define TC_INT_EN_BIT 5

`define TC_HOLDOFF_CYCLES 2'h2

`endif

// [hdl/timer_pkg.sv]
// Types shared by the timer design
package timer_pkg;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic [7:0] count;
    logic [7:0] option;
    logic [7:0] presc;
    logic [1:0] holdoff;
    logic flag;
    logic irq_en;
    logic pin_prev;
    logic sync1;
    logic sync2;
    logic sync3;
    logic irq;
    logic wd_tick;
    logic wd_reset;
  } timer_state_t;

endpackage

// [hdl/timer_core.sv]
// 8-bit timer/counter with shared prescaler behind an Avalon-MM slave
`timescale 1ns/1ps
`include "timer_regs.svh"

module timer_core
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_instr_cycle,
  input wire logic i_q2,
  input wire logic i_q4,
  input wire logic i_sleep,
  input wire logic i_external_count_pin,
  input wire logic i_watchdog_osc_tick,
  input wire logic i_watchdog_clear_instruction,
  output logic o_watchdog_tick,
  output logic o_watchdog_reset,
  output logic o_irq
);
  import timer_pkg::*;

  timer_state_t state_reg;
  timer_state_t state_next;

  // Low-bit mask covering the first k prescaler bits
  function automatic logic [7:0] low_mask(input logic [3:0] k);
    logic [8:0] m;
    m = 9'h000;
    m = (9'h001 << k) - 9'h001;
    return m[7:0];
  endfunction

  // Decoded option fields
  logic [2:0] rate;
  logic owner_wd;
  logic src_ext;
  logic edge_fall;
  assign rate = state_reg.option[`TC_OPT_RATE_MSB:`TC_OPT_RATE_LSB];
  assign owner_wd = state_reg.option[`TC_OPT_OWNER_BIT];
  assign src_ext = state_reg.option[`TC_OPT_SRC_BIT];
  assign edge_fall = state_reg.option[`TC_OPT_EDGE_BIT];

  // Register outputs
  assign o_avs_readdata = state_reg.rdata;
  assign o_avs_waitrequest = state_reg.bus[0];
  assign o_irq = state_reg.irq;
  assign o_watchdog_tick = state_reg.wd_tick;
  assign o_watchdog_reset = state_reg.wd_reset;

  // Next-state logic for bus, prescaler and counter
  always_comb
  begin
    logic req;
    logic do_acc;
    logic wr_en;
    logic wr_count;
    logic wr_intctl;
    logic wr_option;
    logic pin_level;
    logic pin_rise;
    logic presc_ev;
    logic [7:0] tmask;
    logic [7:0] wmask;
    logic int_tick;
    logic ext_tick;
    logic sync_src;
    logic inc;
    logic ovf;
    logic flag_clr;
    logic [31:0] rd;
    req = 1'b0;
    do_acc = 1'b0;
    wr_en = 1'b0;
    wr_count = 1'b0;
    wr_intctl = 1'b0;
    wr_option = 1'b0;
    pin_level = 1'b0;
    pin_rise = 1'b0;
    presc_ev = 1'b0;
    tmask = 8'h00;
    wmask = 8'h00;
    int_tick = 1'b0;
    ext_tick = 1'b0;
    sync_src = 1'b0;
    inc = 1'b0;
    ovf = 1'b0;
    flag_clr = 1'b0;
    rd = 32'h0000_0000;
    state_next = state_reg;
    state_next.wd_tick = 1'b0;
    state_next.wd_reset = 1'b0;

    // Bus handshake: one wait cycle, then the access completes
    req = i_avs_read | i_avs_write;
    case (state_reg.bus)
      BUS_IDLE:
      begin
        if (req)
        begin
          state_next.bus = BUS_ACK;
        end
      end
      BUS_ACK:
      begin
        do_acc = req;
        state_next.bus = BUS_IDLE;
      end
      default:
      begin
        state_next.bus = BUS_IDLE;
      end
    endcase

    // Read data is captured on the wait cycle so it stands when waitrequest drops
    case (i_avs_address)
      `TC_IDX_COUNT: rd[7:0] = state_reg.count;
      `TC_IDX_INTCTL:
      begin
        rd[`TC_INT_FLAG_BIT] = state_reg.flag;
        rd[`TC_INT_EN_BIT] = state_reg.irq_en;
      end
      `TC_IDX_OPTION: rd[7:0] = state_reg.option;
      default: rd = 32'h0000_0000; // Unmapped and prescaler value read zero
    endcase
    if (state_reg.bus == BUS_IDLE && i_avs_read)
    begin
      state_next.rdata = rd;
    end

    // Write decode; only the low byte lane carries register bits
    wr_en = do_acc & i_avs_write & i_avs_byteenable[0];
    wr_count = wr_en && (i_avs_address == `TC_IDX_COUNT);
    wr_intctl = wr_en && (i_avs_address == `TC_IDX_INTCTL);
    wr_option = wr_en && (i_avs_address == `TC_IDX_OPTION);

    // Pin level after edge select, so rising always means counting edge
    pin_level = i_external_count_pin ^ edge_fall;
    pin_rise = pin_level & ~state_reg.pin_prev;
    state_next.pin_prev = pin_level;

    // Division masks: timer 2^(rate+1), watchdog 2^rate
    tmask = low_mask({1'b0, rate} + 4'h1);
    wmask = low_mask({1'b0, rate});

    // Shared prescaler advances from whichever side owns it
    if (!owner_wd)
    begin
      // Sleep shuts off the timer side of the prescaler as well
      presc_ev = (src_ext ? pin_rise : i_instr_cycle) & ~i_sleep;
      int_tick = presc_ev & ~src_ext & ((state_reg.presc & tmask) == tmask);
    end
    else
    begin
      presc_ev = i_watchdog_osc_tick;
      state_next.wd_tick = presc_ev & ((state_reg.presc & wmask) == wmask);
    end
    if (presc_ev)
    begin
      state_next.presc = state_reg.presc + 8'h01;
    end

    // Clearing the prescaler from a count write or a watchdog clear
    if (!owner_wd && wr_count)
    begin
      state_next.presc = 8'h00;
    end
    if (owner_wd && i_watchdog_clear_instruction)
    begin
      state_next.presc = 8'h00;
      state_next.wd_reset = 1'b1;
    end

    // External path: prescaler output when owned, raw edge-selected pin otherwise
    sync_src = (!owner_wd) ? state_reg.presc[rate] : pin_level;
    if (i_q2)
    begin
      state_next.sync1 = sync_src;
    end
    if (i_q4)
    begin
      state_next.sync2 = state_reg.sync1;
    end
    state_next.sync3 = state_reg.sync2;
    ext_tick = state_reg.sync2 & ~state_reg.sync3;

    // Count event selection; watchdog ownership leaves the timer at 1:1
    if (src_ext)
    begin
      inc = ext_tick;
    end
    else if (owner_wd)
    begin
      inc = i_instr_cycle;
    end
    else
    begin
      inc = int_tick;
    end

    // Hold-off after a count write, counted in instruction cycles
    if (state_reg.holdoff != 2'h0)
    begin
      inc = 1'b0;
      if (i_instr_cycle)
      begin
        state_next.holdoff = state_reg.holdoff - 2'h1;
      end
    end

    // Sleep stops the counter outright
    if (i_sleep)
    begin
      inc = 1'b0;
    end

    // Counter update; a software write beats a coincident increment
    if (wr_count)
    begin
      state_next.count = i_avs_writedata[7:0];
      state_next.holdoff = `TC_HOLDOFF_CYCLES;
    end
    else if (inc)
    begin
      ovf = (state_reg.count == `TC_COUNT_MAX);
      state_next.count = state_reg.count + 8'h01;
    end

    // Option register steers source, edge, owner and rate
    if (wr_option)
    begin
      state_next.option = i_avs_writedata[7:0];
    end

    // Interrupt control: enable stored, flag cleared by writing one
    if (wr_intctl)
    begin
      state_next.irq_en = i_avs_writedata[`TC_INT_EN_BIT];
      flag_clr = i_avs_writedata[`TC_INT_FLAG_BIT];
    end
    // Set beats clear so an overflow in the clearing cycle is kept
    state_next.flag = (state_reg.flag & ~flag_clr) | ovf;
    state_next.irq = state_next.flag & state_next.irq_en;
  end

  // State register; clock enable freezes everything
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg <= '{
        bus: BUS_IDLE,
        rdata: 32'h0000_0000,
        count: `TC_COUNT_RESET,
        option: `TC_OPT_RESET,
        presc: 8'h00,
        holdoff: 2'h0,
        flag: 1'b0,
        irq_en: 1'b0,
        pin_prev: 1'b0,
        sync1: 1'b0,
        sync2: 1'b0,
        sync3: 1'b0,
        irq: 1'b0,
        wd_tick: 1'b0,
        wd_reset: 1'b0
      };
    end
    else if (i_clk_en)
    begin
      state_reg <= state_next;
    end
  end

endmodule

// [verification/phase_gen.sv]
// Instruction-cycle phase strobes standing in for the processor clocking
`timescale 1ns/1ps
module phase_gen
(
  input wire logic i_ref_clk,
  input wire logic i_go,
  output logic o_q2,
  output logic o_q4
);
  logic [1:0] phase_reg;
  // Phase restarts at zero when halted, so each step is exact
  always_ff @(posedge i_ref_clk)
  begin
    phase_reg <= i_go ? phase_reg + 2'h1 : 2'h0;
  end
  // Strobes only while running; q4 doubles as the cycle pulse
  assign o_q2 = i_go && phase_reg == 2'h1;
  assign o_q4 = i_go && phase_reg == 2'h3;
endmodule

// [verification/timer_core_monitor.sv]
// Port-level assertions for the timer core
`timescale 1ns/1ps
module timer_core_monitor
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_sleep,
  input wire logic i_watchdog_osc_tick,
  input wire logic i_watchdog_clear_instruction,
  input wire logic o_watchdog_tick,
  input wire logic o_watchdog_reset,
  input wire logic o_irq
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Bus answers in the next cycle, and for one cycle only
  wait_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus answer late");
  wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  rdata_upper_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h02 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // Sleep stops the counter, so only a write can raise the request then
  irq_sleep_a: assert property ($rose(o_irq) |-> !$past(i_sleep) || $past(i_avs_write))
    else $error("irq rose in sleep");
  irq_sticky_a: assert property ($fell(o_irq) |-> $past(i_avs_write))
    else $error("irq fell without write");
  wd_tick_a: assert property (o_watchdog_tick |-> $past(i_watchdog_osc_tick))
    else $error("watchdog tick without cause");
  wd_clear_a: assert property (o_watchdog_reset |-> $past(i_watchdog_clear_instruction))
    else $error("watchdog reset without clear");
  cover property ($rose(o_irq));
  cover property (o_watchdog_tick);
  cover property (o_watchdog_reset);
endmodule
bind timer_core timer_core_monitor i_mon (
  .i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_sleep(i_sleep),
  .i_watchdog_osc_tick(i_watchdog_osc_tick),
  .i_watchdog_clear_instruction(i_watchdog_clear_instruction),
  .o_watchdog_tick(o_watchdog_tick),
  .o_watchdog_reset(o_watchdog_reset),
  .o_irq(o_irq)
);

// [verification/eight_bit_timer_with_shared_prescaler_bench.sv]
// Self-checking bench for the 8-bit timer core
`timescale 1ns/1ps
`include "timer_regs.svh"
module eight_bit_timer_with_shared_prescaler_bench;
  logic clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, go = 1'h0;
  logic sleep = 1'h0, pin = 1'h0, osc = 1'h0, clr = 1'h0;
  logic q2, q4, busy, wdt, wdr, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, c0;
  int n_errors = 0;
  int checks_done = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  phase_gen i_gen (.i_ref_clk(clk), .i_go(go), .o_q2(q2), .o_q4(q4));
  timer_core i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'h1),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(busy),
    .i_instr_cycle(q4), .i_q2(q2), .i_q4(q4), .i_sleep(sleep), .i_external_count_pin(pin),
    .i_watchdog_osc_tick(osc), .i_watchdog_clear_instruction(clr),
    .o_watchdog_tick(wdt), .o_watchdog_reset(wdr), .o_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, then an idle edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    @(posedge clk);
    while (busy === 1'h1)
      @(posedge clk);
    v = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00);
    chk(v, e);
  endtask
  // Exactly n instruction cycles, plus an edge for the last count to land
  task automatic step(input int n);
    go <= 1'h1;
    repeat (4 * n) @(posedge clk);
    go <= 1'h0;
    @(posedge clk);
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      pin <= 1'h1;
      step(1);
      pin <= 1'h0;
      step(1);
    end
  endtask
  // Watchdog clear pulse, launched and dropped on rising edges
  task automatic wd_clear;
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic t_regs;
    rd_chk(`TC_IDX_OPTION, 32'hFF);
    rd_chk(`TC_IDX_COUNT, 32'h00);
    rd_chk(`TC_IDX_INTCTL, 32'h00);
    rd_chk(8'h02, 32'h00);
    $display("register defaults done");
  endtask
  task automatic t_count;
    wr_reg(`TC_IDX_OPTION, 8'h08);
    wr_reg(`TC_IDX_COUNT, 8'hFE);
    step(2);
    rd_chk(`TC_IDX_COUNT, 32'hFE);
    step(1);
    rd_chk(`TC_IDX_COUNT, 32'hFF);
    step(1);
    rd_chk(`TC_IDX_COUNT, 32'h00);
    rd_chk(`TC_IDX_INTCTL, 32'h04);
    chk(irq, 32'h0);
    wr_reg(`TC_IDX_INTCTL, 8'h20);
    chk(irq, 32'h1);
    wr_reg(`TC_IDX_INTCTL, 8'h24);
    chk(irq, 32'h0);
    rd_chk(`TC_IDX_INTCTL, 32'h20);
    $display("timer mode done");
  endtask
  // Steps are whole multiples of every division, so the delta is exact
  task automatic t_rates;
    wd_clear();
    for (int r = 0; r < 8; r++)
    begin
      wr_reg(`TC_IDX_OPTION, 8'(r));
      wr_reg(`TC_IDX_COUNT, 8'h00);
      step(2);
      bus(1'h0, `TC_IDX_COUNT, 8'h00);
      c0 = v;
      step(256);
      rd_chk(`TC_IDX_COUNT, c0 + 32'(256 >> (r + 1)));
    end
    step(100);
    wr_reg(`TC_IDX_COUNT, 8'h10);
    step(200);
    rd_chk(`TC_IDX_COUNT, 32'h10);
    $display("prescaler rates done");
  endtask
  // Hand the prescaler to the watchdog with the safe clear sequence first
  task automatic t_ext;
    wd_clear();
    wr_reg(`TC_IDX_COUNT, 8'h00);
    wr_reg(`TC_IDX_OPTION, 8'h2F);
    wd_clear();
    wr_reg(`TC_IDX_OPTION, 8'h28);
    wr_reg(`TC_IDX_COUNT, 8'h00);
    step(2);
    pulse(3);
    rd_chk(`TC_IDX_COUNT, 32'h03);
    wr_reg(`TC_IDX_OPTION, 8'h38);
    step(2);
    bus(1'h0, `TC_IDX_COUNT, 8'h00);
    c0 = v;
    pulse(3);
    rd_chk(`TC_IDX_COUNT, c0 + 32'h3);
    sleep <= 1'h1;
    pulse(3);
    sleep <= 1'h0;
    rd_chk(`TC_IDX_COUNT, c0 + 32'h3);
    // Prescaler back on the pin path at 1:2, so four edges give two counts
    wd_clear();
    wr_reg(`TC_IDX_OPTION, 8'h20);
    wr_reg(`TC_IDX_COUNT, 8'h00);
    step(2);
    pulse(4);
    rd_chk(`TC_IDX_COUNT, 32'h02);
    $display("external count done");
  endtask
  task automatic t_wdt;
    logic [31:0] k;
    for (int r = 0; r < 4; r++)
    begin
      wr_reg(`TC_IDX_OPTION, 8'h08 | 8'(r));
      wd_clear();
      chk(wdr, 32'h1);
      k = 32'h0;
      // Tick output is taken one edge after the oscillator pulse is seen
      repeat (16)
      begin
        osc <= 1'h1;
        @(posedge clk);
        osc <= 1'h0;
        @(posedge clk);
        k += wdt;
      end
      chk(k, 32'(16 >> r));
    end
    $display("watchdog share done");
  endtask
  task automatic finish_test;
    $display("errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reset for 12 cycles, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_count();
    t_rates();
    t_ext();
    t_wdt();
    finish_test();
  end
  // Run needs about 10k cycles; cut a hang well beyond that
  initial
  begin
    #300000;
    n_errors++;
    finish_test();
  end
endmodule
